// File: hw/dls_params.svh
`ifndef DLS_PARAMS_SVH
`define DLS_PARAMS_SVH
// Register byte offsets
`define DLS_OFF_CTRL     8'h00
`define DLS_OFF_INTERVAL 8'h04
`define DLS_OFF_MAXDUR   8'h08
`define DLS_OFF_PERIODIC 8'h0C
`define DLS_OFF_SCHSTART 8'h10
`define DLS_OFF_SCHSTOP  8'h14
`define DLS_OFF_USER     8'h18
`define DLS_OFF_SITE     8'h1C
`define DLS_OFF_SERIAL   8'h20
`define DLS_OFF_CALDATE  8'h24
`define DLS_OFF_ALARM    8'h28
`define DLS_OFF_STATUS   8'h2C
`define DLS_OFF_INTSTAT  8'h30
`define DLS_OFF_INTMASK  8'h34
`define DLS_OFF_WADDR    8'h38
// Control fields
`define DLS_CTRL_MODE_LO 0
`define DLS_CTRL_MEAS    2
`define DLS_CTRL_MCLR    3
// Interval limits in seconds; DLS_LOG_MAX_MIN in minutes
`define DLS_INT_MIN_SEC  12'h001
`define DLS_LOG_MAX_MIN  60
`define DLS_LOG_MAX_SEC  (`DLS_LOG_MAX_MIN * 60)
// Event and memory sizes
`define DLS_EV_MAX       10'h384
`define DLS_MEM_LAST     16'hFFFF
`define DLS_NSENS        4
`define DLS_HDR_WORDS    4'h7
// Full-memory flash: lit half of each second
`define DLS_CLK_NS       25
`define DLS_FLASH_ON_NS  500000000
// Record word kinds
`define DLS_K_START      4'h1
`define DLS_K_PERIOD     4'h2
`define DLS_K_ALARM      4'h3
`define DLS_K_USER       4'h4
`define DLS_K_SITE       4'h5
`define DLS_K_SERIAL     4'h6
`define DLS_K_CALDATE    4'h7
`define DLS_K_STAMP      4'h8
`define DLS_K_MEAS       4'h9
`endif

// File: hw/dls_pkg.sv
package dls_pkg;
  typedef enum logic [1:0] {
    DLS_AUTO   = 2'h0,
    DLS_MANUAL = 2'h1,
    DLS_PERIOD = 2'h2,
    DLS_SCHED  = 2'h3
  } dls_mode_t;

  typedef enum logic [2:0] {
    WR_IDLE = 3'b001,
    WR_HDR  = 3'b010,
    WR_REC  = 3'b100
  } dls_wr_t;

  typedef struct packed {
    logic [3:0] month;
    logic [4:0] day;
    logic [4:0] hour;
    logic [5:0] minute;
    logic [5:0] second;
  } dls_rtc_t;

  typedef struct packed {
    logic [3:0]  kind;
    logic [27:0] data;
  } dls_word_t;
endpackage : dls_pkg

// File: hw/dls_logger.sv
// Functional notes
// - Logging interval programmable 1 s to 60 min in 1 s steps.
// - Each interval stores per sensor the mean or the peak, by setting.
// - Store time stamp, user, site, serial, calibration date and alarm limits.
// - Records go to non-volatile store for later upload.
// - Automatic mode logs from power-on until power-off.
// - Manual mode: confirm key toggles logging while start/stop prompt shown.
// - Manual mode has a maximum-duration timer ending the session.
// - Periodic mode starts and stops daily on hour and minute match.
// - Scheduled mode starts and stops on month, day, hour, minute match.
// - Each start opens an event: header first, then measurement records.
// - Beyond 900 intervals an event closes and a fresh one opens.
// - Programming mode suspends logging; leaving it resumes logging.
// - Standby suspends; on exit only automatic mode resumes logging.
// - Any resume after suspension opens a new event.
// - Full store shows one flash per second and a memory message.
//
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "dls_params.svh"

module dls_logger
  import dls_pkg::*;
#(
  parameter int FLASH_ON_CYC = `DLS_FLASH_ON_NS / `DLS_CLK_NS
) (
  // Clock, reset, enable
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic               ce,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Unit pins
  input  wire logic               powerOn,
  input  wire logic               keyConfirm,
  input  wire logic               promptShown,
  input  wire logic               progMode,
  input  wire logic               pcStandby,
  // Timebase and samples
  input  wire logic               secTick,
  input  dls_rtc_t                rtcNow,
  input  wire logic               sampleValid,
  input  wire logic [1:0]         sampleSensor,
  input  wire logic [15:0]        sampleValue,
  // Log store write port
  output logic                    memValid,
  output logic      [15:0]        memAddr,
  output dls_word_t               memData,
  input  wire logic               memReady,
  // Indicators
  output logic                    memFull,
  output logic                    memFlash,
  output logic                    memMsg,
  output logic                    irq
);

  logic [4:0]  pinS1, pinS2;
  logic        confirmPrev, standbyPrev, activePrev;
  dls_mode_t   mode;
  logic        measPeak;
  logic [11:0] interval, maxDur, durCnt, secCnt;
  logic [21:0] periodic;
  logic [19:0] schStart, schStop;
  logic [27:0] userId, siteId, serialNo, calDate, alarmLim;
  logic [2:0]  intStat, intMask;
  logic        logOn, needHdr, pendRec, intervalEnd;
  logic [9:0]  evCount;
  dls_wr_t     wrSt;
  logic [3:0]  wrIdx;
  logic [24:0] flashCnt;
  logic [27:0] accSum  [`DLS_NSENS];
  logic [15:0] accPeak [`DLS_NSENS];
  logic [11:0] accCnt  [`DLS_NSENS];
  logic [15:0] resVal  [`DLS_NSENS];
  dls_rtc_t    resTime, evTime;

  wire logic powerS    = pinS2[0];
  wire logic confirmS  = pinS2[1];
  wire logic promptS   = pinS2[2];
  wire logic progS     = pinS2[3];
  wire logic standbyS  = pinS2[4];
  wire logic suspended = progS | standbyS | standbyPrev;
  wire logic active    = logOn & ~suspended & ~memFull;
  wire logic apbAcc    = psel & penable & pready;
  wire logic apbWr     = apbAcc & pwrite;
  wire logic apbRd     = apbAcc & ~pwrite;
  wire logic wordTaken = memValid & memReady;
  wire logic lastHdr   = (wrSt == WR_HDR) && (wrIdx == `DLS_HDR_WORDS - 4'h1);
  wire logic lastRec   = (wrSt == WR_REC) && (wrIdx == 4'(`DLS_NSENS));
  wire logic memClr    = apbWr && (paddr == `DLS_OFF_CTRL) && pwdata[`DLS_CTRL_MCLR];
  wire logic fullSet   = wordTaken && (memAddr == `DLS_MEM_LAST);
  wire logic evOpened  = wordTaken && lastHdr;
  wire logic recDone   = wordTaken && lastRec;

  function automatic logic [15:0] meanOf(input logic [27:0] sum, input logic [11:0] cnt);
    logic [27:0] q;
    q = (cnt == 12'h000) ? 28'h0000000 : sum / {16'h0000, cnt};
    return q[15:0];
  endfunction : meanOf

  function automatic logic rtcHit(input dls_rtc_t t, input logic [19:0] tgt, input logic full);
    return (t.hour == tgt[10:6]) && (t.minute == tgt[5:0]) &&
           (!full || ((t.month == tgt[19:16]) && (t.day == tgt[15:11])));
  endfunction : rtcHit

  function automatic logic [11:0] clampInterval(input logic [31:0] v);
    if (v == 32'h0) begin
      return `DLS_INT_MIN_SEC;
    end else if (v > 32'(`DLS_LOG_MAX_SEC)) begin
      return 12'(`DLS_LOG_MAX_SEC);
    end
    return v[11:0];
  endfunction : clampInterval

  function automatic dls_word_t wordFor(input dls_wr_t st, input logic [3:0] idx);
    dls_word_t w;
    w = '0;
    if (st == WR_HDR) begin
      case (idx)
        4'h0: w = '{`DLS_K_START, {2'h0, evTime}};
        4'h1: w = '{`DLS_K_PERIOD, {15'h0000, measPeak, interval}};
        4'h2: w = '{`DLS_K_ALARM, alarmLim};
        4'h3: w = '{`DLS_K_USER, userId};
        4'h4: w = '{`DLS_K_SITE, siteId};
        4'h5: w = '{`DLS_K_SERIAL, serialNo};
        default: w = '{`DLS_K_CALDATE, calDate};
      endcase
    end else if (idx == 4'h0) begin
      w = '{`DLS_K_STAMP, {2'h0, resTime}};
    end else begin
      w = '{`DLS_K_MEAS, {10'h000, 2'(idx - 4'h1), resVal[2'(idx - 4'h1)]}};
    end
    return w;
  endfunction : wordFor

  // Pin synchronisers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pinS1 <= 5'h00;
      pinS2 <= 5'h00;
    end else if (ce) begin
      pinS1 <= {pcStandby, progMode, promptShown, keyConfirm, powerOn};
      pinS2 <= pinS1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      confirmPrev <= 1'b0;
      standbyPrev <= 1'b0;
      activePrev  <= 1'b0;
    end else if (ce) begin
      confirmPrev <= confirmS;
      standbyPrev <= standbyS;
      activePrev  <= active;
    end
  end

  // Configuration registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode     <= DLS_AUTO;
      measPeak <= 1'b0;
      interval <= `DLS_INT_MIN_SEC;
      maxDur   <= 12'h000;
      periodic <= 22'h000000;
      schStart <= 20'h00000;
      schStop  <= 20'h00000;
      userId   <= 28'h0000000;
      siteId   <= 28'h0000000;
      serialNo <= 28'h0000000;
      calDate  <= 28'h0000000;
      alarmLim <= 28'h0000000;
      intMask  <= 3'h0;
    end else if (ce && apbWr) begin
      case (paddr)
        `DLS_OFF_CTRL: begin
          mode     <= dls_mode_t'(pwdata[`DLS_CTRL_MODE_LO +: 2]);
          measPeak <= pwdata[`DLS_CTRL_MEAS];
        end
        `DLS_OFF_INTERVAL: interval <= clampInterval(pwdata);
        `DLS_OFF_MAXDUR:   maxDur   <= pwdata[11:0];
        `DLS_OFF_PERIODIC: periodic <= pwdata[21:0];
        `DLS_OFF_SCHSTART: schStart <= pwdata[19:0];
        `DLS_OFF_SCHSTOP:  schStop  <= pwdata[19:0];
        `DLS_OFF_USER:     userId   <= pwdata[27:0];
        `DLS_OFF_SITE:     siteId   <= pwdata[27:0];
        `DLS_OFF_SERIAL:   serialNo <= pwdata[27:0];
        `DLS_OFF_CALDATE:  calDate  <= pwdata[27:0];
        `DLS_OFF_ALARM:    alarmLim <= pwdata[27:0];
        `DLS_OFF_INTMASK:  intMask  <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // Session request per trigger mode
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      logOn <= 1'b0;
    end else if (ce) begin
      case (mode)
        DLS_AUTO: logOn <= powerS;
        DLS_MANUAL: begin
          if (confirmS && !confirmPrev && promptS) begin
            logOn <= ~logOn;
          end else if (maxDur != 12'h000 && durCnt >= maxDur) begin
            logOn <= 1'b0;
          end
        end
        DLS_PERIOD: begin
          if (secTick && rtcNow.second == 6'h00) begin
            if (rtcHit(rtcNow, {9'h000, periodic[21:11]}, 1'b0)) begin
              logOn <= 1'b1;
            end else if (rtcHit(rtcNow, {9'h000, periodic[10:0]}, 1'b0)) begin
              logOn <= 1'b0;
            end
          end
        end
        DLS_SCHED: begin
          if (secTick && rtcNow.second == 6'h00) begin
            if (rtcHit(rtcNow, schStart, 1'b1)) begin
              logOn <= 1'b1;
            end else if (rtcHit(rtcNow, schStop, 1'b1)) begin
              logOn <= 1'b0;
            end
          end
        end
        default: logOn <= 1'b0;
      endcase
      if (standbyPrev && !standbyS && mode != DLS_AUTO) begin
        logOn <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      durCnt <= 12'h000;
    end else if (ce) begin
      if (!logOn || mode != DLS_MANUAL) begin
        durCnt <= 12'h000;
      end else if (secTick && active && durCnt != 12'hFFF) begin
        durCnt <= durCnt + 12'h001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      secCnt      <= 12'h000;
      intervalEnd <= 1'b0;
    end else if (ce) begin
      intervalEnd <= 1'b0;
      if (!active) begin
        secCnt <= 12'h000;
      end else if (secTick) begin
        if (secCnt + 12'h001 >= interval) begin
          secCnt      <= 12'h000;
          intervalEnd <= 1'b1;
        end else begin
          secCnt <= secCnt + 12'h001;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < `DLS_NSENS; i++) begin
        accSum[i]  <= 28'h0000000;
        accPeak[i] <= 16'h0000;
        accCnt[i]  <= 12'h000;
        resVal[i]  <= 16'h0000;
      end
      resTime <= '0;
    end else if (ce) begin
      for (int i = 0; i < `DLS_NSENS; i++) begin
        if (!active || intervalEnd) begin
          accSum[i]  <= 28'h0000000;
          accPeak[i] <= 16'h0000;
          accCnt[i]  <= 12'h000;
        end else if (sampleValid && sampleSensor == 2'(i)) begin
          accSum[i]  <= accSum[i] + {12'h000, sampleValue};
          accPeak[i] <= (sampleValue > accPeak[i]) ? sampleValue : accPeak[i];
          accCnt[i]  <= accCnt[i] + 12'h001;
        end
        if (intervalEnd && active) begin
          resVal[i] <= measPeak ? accPeak[i] : meanOf(accSum[i], accCnt[i]);
        end
      end
      if (intervalEnd && active) begin
        resTime <= rtcNow;
      end
    end
  end

  // Event bookkeeping
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      needHdr <= 1'b0;
      pendRec <= 1'b0;
      evCount <= 10'h000;
      evTime  <= '0;
    end else if (ce) begin
      if (active && !activePrev) begin
        needHdr <= 1'b1;
        evTime  <= rtcNow;
      end else if (wrSt == WR_IDLE && pendRec && !needHdr && evCount == `DLS_EV_MAX) begin
        needHdr <= 1'b1;
        evTime  <= rtcNow;
      end else if (wrSt == WR_IDLE && needHdr && active) begin
        needHdr <= 1'b0;
      end
      if (!active) begin
        pendRec <= 1'b0;
      end else if (intervalEnd) begin
        pendRec <= 1'b1;
      end else if (wrSt == WR_IDLE && !needHdr && pendRec && evCount != `DLS_EV_MAX) begin
        pendRec <= 1'b0;
      end
      if (evOpened) begin
        evCount <= 10'h000;
      end else if (recDone) begin
        evCount <= evCount + 10'h001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wrSt     <= WR_IDLE;
      wrIdx    <= 4'h0;
      memValid <= 1'b0;
      memData  <= '0;
    end else if (ce) begin
      case (wrSt)
        WR_IDLE: begin
          wrIdx <= 4'h0;
          if (active && needHdr) begin
            wrSt     <= WR_HDR;
            memValid <= 1'b1;
            memData  <= wordFor(WR_HDR, 4'h0);
          end else if (active && pendRec && evCount != `DLS_EV_MAX) begin
            wrSt     <= WR_REC;
            memValid <= 1'b1;
            memData  <= wordFor(WR_REC, 4'h0);
          end
        end
        WR_HDR, WR_REC: begin
          if (fullSet || (wordTaken && (lastHdr || lastRec))) begin
            wrSt     <= WR_IDLE;
            memValid <= 1'b0;
          end else if (wordTaken) begin
            wrIdx   <= wrIdx + 4'h1;
            memData <= wordFor(wrSt, wrIdx + 4'h1);
          end
        end
        default: begin
          wrSt     <= WR_IDLE;
          memValid <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      memAddr <= 16'h0000;
      memFull <= 1'b0;
    end else if (ce) begin
      if (fullSet) begin
        memFull <= 1'b1;
      end else if (memClr) begin
        memFull <= 1'b0;
      end
      if (memClr && !wordTaken) begin
        memAddr <= 16'h0000;
      end else if (wordTaken && !fullSet) begin
        memAddr <= memAddr + 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flashCnt <= 25'h0000000;
      memFlash <= 1'b0;
      memMsg   <= 1'b0;
    end else if (ce) begin
      memMsg <= memFull;
      if (!memFull) begin
        memFlash <= 1'b0;
        flashCnt <= 25'h0000000;
      end else if (secTick) begin
        memFlash <= 1'b1;
        flashCnt <= 25'(FLASH_ON_CYC);
      end else if (flashCnt != 25'h0000000) begin
        flashCnt <= flashCnt - 25'h0000001;
      end else begin
        memFlash <= 1'b0;
      end
    end
  end

  // Sticky events, cleared by reading; set wins
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      intStat <= 3'h0;
      irq     <= 1'b0;
    end else if (ce) begin
      intStat <= ((apbRd && paddr == `DLS_OFF_INTSTAT) ? 3'h0 : intStat) |
                 {fullSet, recDone, evOpened};
      irq     <= |(intStat & intMask);
    end
  end

  // APB answer: one wait-free access phase
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (ce) begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (psel && !penable) begin
        case (paddr)
          `DLS_OFF_CTRL:     prdata <= {29'h0, measPeak, mode};
          `DLS_OFF_INTERVAL: prdata <= {20'h0, interval};
          `DLS_OFF_MAXDUR:   prdata <= {20'h0, maxDur};
          `DLS_OFF_PERIODIC: prdata <= {10'h0, periodic};
          `DLS_OFF_SCHSTART: prdata <= {12'h0, schStart};
          `DLS_OFF_SCHSTOP:  prdata <= {12'h0, schStop};
          `DLS_OFF_USER:     prdata <= {4'h0, userId};
          `DLS_OFF_SITE:     prdata <= {4'h0, siteId};
          `DLS_OFF_SERIAL:   prdata <= {4'h0, serialNo};
          `DLS_OFF_CALDATE:  prdata <= {4'h0, calDate};
          `DLS_OFF_ALARM:    prdata <= {4'h0, alarmLim};
          `DLS_OFF_STATUS: begin
            prdata <= {17'h0, suspended, memFull, wrSt != WR_IDLE, active, logOn, evCount};
          end
          `DLS_OFF_INTSTAT:  prdata <= {29'h0, intStat};
          `DLS_OFF_INTMASK:  prdata <= {29'h0, intMask};
          `DLS_OFF_WADDR:    prdata <= {16'h0, memAddr};
          default:           pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule : dls_logger

// File: testbench/dls_checker_assertions.sv
`timescale 1ns/1ps
module dls_checker
  import dls_pkg::*;
#(
  parameter int FLASH_ON_CYC = 10
) (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  // Second tick, store and indicators
  input wire logic        secTick,
  input wire logic        memValid,
  input wire logic [15:0] memAddr,
  input dls_word_t        memData,
  input wire logic        memReady,
  input wire logic        memFull,
  input wire logic        memFlash,
  input wire logic        memMsg
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic take;
  logic clrWr;
  int   flashRun;
  assign take = memValid && memReady;
  assign clrWr = psel && penable && pready && pwrite && paddr == 8'h00 && pwdata[3];
  // Length of the current lit stretch of the flash
  always_ff @(posedge ref_clk) begin
    if (rst) flashRun <= 0;
    else flashRun <= memFlash ? flashRun + 1 : 0;
  end
  a_msg_follow:
    assert property (1'b1 |=> memMsg == $past(memFull)) else $error("memory message lag");
  a_flash_on:
    assert property (memFull && secTick |=> memFlash [*8]) else $error("flash not lit");
  a_flash_len:
    assert property (flashRun <= FLASH_ON_CYC + 1) else $error("flash too long");
  a_full_sticky:
    assert property (memFull && !clrWr |=> memFull) else $error("full flag dropped");
  a_full_nowrite:
    assert property (memFull |-> !take) else $error("write while full");
  a_hdr_order:
    assert property (take && memData.kind inside {[4'h1:4'h6]} && memAddr != 16'hFFFF
      |=> memValid && memData.kind == $past(memData.kind) + 4'h1) else $error("header order");
  a_rec_order:
    assert property (take && memData.kind == 4'h8 && memAddr != 16'hFFFF
      |=> memValid && memData.kind == 4'h9) else $error("record order");
  a_word_hold:
    assert property (memValid && !memReady |=> memValid && $stable(memData) && $stable(memAddr))
      else $error("word not held");
  a_addr_step:
    assert property (take && memAddr != 16'hFFFF && !clrWr |=> memAddr == $past(memAddr) + 16'h1)
      else $error("address step");
endmodule : dls_checker

bind dls_logger dls_checker #(.FLASH_ON_CYC(FLASH_ON_CYC)) chk_i (
  .ref_clk, .rst, .psel, .penable, .pwrite, .pready, .paddr, .pwdata, .secTick,
  .memValid, .memAddr, .memData, .memReady, .memFull, .memFlash, .memMsg
);

// File: testbench/dls_store_model.sv
`timescale 1ns/1ps
`include "dls_params.svh"
module dls_store_model
  import dls_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Stall control
  input  wire logic        slow,
  // Store write port
  input  wire logic        memValid,
  input  wire logic [15:0] memAddr,
  input  dls_word_t        memData,
  output logic             memReady
);
  int          hdrCnt = 0;
  int          recCnt = 0;
  int          runCnt = 0;
  int          lastRun = 0;
  int          gaps = 0;
  logic [15:0] nextAddr = 16'h0000;
  logic [27:0] kindData [16];
  logic [15:0] measVal [4];
  // Accept every cycle, or every other one when stalling
  always_ff @(posedge ref_clk) begin
    if (rst) memReady <= 1'b0;
    else memReady <= slow ? ~memReady : 1'b1;
  end
  always @(posedge ref_clk) begin
    if (!rst && memValid && memReady) begin
      if (memAddr != nextAddr) gaps++;
      nextAddr = memAddr + 16'h0001;
      kindData[memData.kind] = memData.data;
      if (memData.kind == `DLS_K_START) begin
        hdrCnt++;
        lastRun = runCnt;
        runCnt = 0;
      end
      if (memData.kind == `DLS_K_STAMP) begin
        recCnt++;
        runCnt++;
      end
      if (memData.kind == `DLS_K_MEAS) measVal[memData.data[17:16]] = memData.data[15:0];
    end
  end
endmodule : dls_store_model

// File: testbench/tb.sv
`timescale 1ns/1ps
module tb
  import dls_pkg::*;
;
  logic        ref_clk = 1'b0, rst = 1'b1, ce = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, powerOn = 1'b0, keyConfirm = 1'b0, promptShown = 1'b0;
  logic        progMode = 1'b0, pcStandby = 1'b0, secTick = 1'b0, sampleValid = 1'b0;
  logic        slow = 1'b0, pready, pslverr, memValid, memReady, memFull, memFlash, memMsg, irq;
  logic [7:0]  paddr = 8'h00;
  logic        err;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0]  sampleSensor = 2'h0;
  logic [15:0] sampleValue = 16'h0, memAddr;
  dls_rtc_t    rtcNow = '0;
  dls_word_t   memData;
  int          bad_count = 0, checked = 0, secCnt = 0, h, r;
  int          wv [4] = '{0, 1234, 3600, 3601};
  int          ev [4] = '{1, 1234, 3600, 3600};

  always #12.5 ref_clk = ~ref_clk;

  // Shortened second: one tick every 20 cycles
  always @(posedge ref_clk) begin
    secCnt <= (secCnt == 19) ? 0 : secCnt + 1;
    secTick <= (secCnt == 19);
  end

  dls_logger #(.FLASH_ON_CYC(10)) uut (
    .ref_clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .powerOn, .keyConfirm, .promptShown, .progMode, .pcStandby, .secTick,
    .rtcNow, .sampleValid, .sampleSensor, .sampleValue, .memValid, .memAddr, .memData,
    .memReady, .memFull, .memFlash, .memMsg, .irq
  );
  dls_store_model mdl (.ref_clk, .rst, .slow, .memValid, .memAddr, .memData, .memReady);

  task automatic final_report();
    if (bad_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : cyc

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  task automatic stat(input logic [31:0] m, input logic [31:0] e, input string w);
    apb(1'b0, 8'h2C, 32'h0);
    chk(w, e, rd & m);
  endtask : stat

  task automatic waitc(ref int c, input int t, input int lim);
    int n;
    n = 0;
    while (c < t && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
    if (c < t) begin
      bad_count++;
      final_report();
    end
  endtask : waitc

  task automatic smp(input logic [1:0] s, input logic [15:0] v);
    sampleValid <= 1'b1;
    sampleSensor <= s;
    sampleValue <= v;
    @(posedge ref_clk);
    sampleValid <= 1'b0;
    @(posedge ref_clk);
  endtask : smp

  task automatic press();
    keyConfirm <= 1'b1;
    cyc(4);
    keyConfirm <= 1'b0;
    cyc(6);
  endtask : press

  initial begin
    cyc(16);
    rst <= 1'b0;
    @(posedge ref_clk);
    apb(1'b0, 8'h3C, 32'h0);
    chk("unmapped error", 1, err);
    chk("unmapped data", 0, rd);
    stat(32'hFFFF_FFFF, 0, "status reset");
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'h04, wv[i]);
      apb(1'b0, 8'h04, 32'h0);
      chk("interval", ev[i], rd);
    end
    for (int i = 0; i < 5; i++) apb(1'b1, 8'(8'h18 + 4 * i), 32'h0A00000 + i);
    apb(1'b1, 8'h0C, {10'h0, 11'h147, 11'h149});
    apb(1'b1, 8'h10, {12'h0, 4'h3, 5'h0C, 11'h147});
    apb(1'b1, 8'h14, {12'h0, 4'h3, 5'h0C, 11'h149});
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h34, 32'h1);
    apb(1'b1, 8'h04, 32'h2);
    powerOn <= 1'b1;
    waitc(mdl.hdrCnt, 1, 300);
    cyc(10);
    stat(32'h0C00, 32'h0C00, "auto logging");
    chk("irq on event", 1, irq);
    for (int i = 0; i < 5; i++) chk("header field", 32'h0A00000 + i, mdl.kindData[i == 4 ? 3 : i + 4]);
    chk("period word", 2, mdl.kindData[2] & 28'hFFF);
    apb(1'b0, 8'h30, 32'h0);
    chk("event flag", 1, rd & 32'h1);
    cyc(3);
    chk("irq cleared", 0, irq);
    r = mdl.recCnt;
    waitc(mdl.recCnt, r + 1, 200);
    smp(2'h0, 16'h000A);
    smp(2'h0, 16'h0014);
    waitc(mdl.recCnt, r + 2, 200);
    cyc(8);
    chk("mean", 32'hF, mdl.measVal[0]);
    chk("empty mean", 0, mdl.measVal[1]);
    apb(1'b1, 8'h00, 32'h4);
    waitc(mdl.recCnt, r + 3, 200);
    smp(2'h1, 16'h000A);
    smp(2'h1, 16'h001E);
    smp(2'h1, 16'h0014);
    waitc(mdl.recCnt, r + 4, 200);
    cyc(8);
    chk("peak", 32'h1E, mdl.measVal[1]);
    apb(1'b1, 8'h34, 32'h0);
    apb(1'b1, 8'h04, 32'h1);
    slow <= 1'b1;
    h = mdl.hdrCnt;
    progMode <= 1'b1;
    cyc(10);
    r = mdl.recCnt;
    cyc(60);
    chk("paused records", r, mdl.recCnt);
    stat(32'h4800, 32'h4000, "prog suspend");
    progMode <= 1'b0;
    waitc(mdl.hdrCnt, h + 1, 300);
    waitc(mdl.hdrCnt, h + 2, 30000);
    chk("event length", 900, mdl.lastRun);
    cyc(40);
    chk("single split header", h + 2, mdl.hdrCnt);
    chk("irq masked", 0, irq);
    slow <= 1'b0;
    h = mdl.hdrCnt;
    pcStandby <= 1'b1;
    cyc(60);
    pcStandby <= 1'b0;
    waitc(mdl.hdrCnt, h + 1, 300);
    powerOn <= 1'b0;
    cyc(10);
    stat(32'h0400, 0, "power off");
    powerOn <= 1'b1;
    waitc(mdl.hdrCnt, h + 2, 300);
    apb(1'b1, 8'h00, 32'h1);
    h = mdl.hdrCnt;
    pcStandby <= 1'b1;
    cyc(10);
    pcStandby <= 1'b0;
    cyc(60);
    stat(32'h0400, 0, "standby exit manual");
    chk("no event", h, mdl.hdrCnt);
    press();
    stat(32'h0400, 0, "key without prompt");
    promptShown <= 1'b1;
    press();
    stat(32'h0400, 32'h0400, "key start");
    press();
    stat(32'h0400, 0, "key stop");
    apb(1'b1, 8'h08, 32'h3);
    press();
    stat(32'h0400, 32'h0400, "timed start");
    cyc(100);
    stat(32'h0400, 0, "max duration");
    for (int m = 2; m < 4; m++) begin
      apb(1'b1, 8'h00, 32'(m));
      rtcNow <= '{4'h3, 5'h0C, 5'h05, 6'h07, 6'h00};
      cyc(40);
      stat(32'h0400, 32'h0400, "time start");
      rtcNow.minute <= 6'h09;
      cyc(40);
      stat(32'h0400, 0, "time stop");
    end
    chk("store not full", 0, {memFull, memMsg, memFlash});
    chk("address gaps", 0, mdl.gaps);
    final_report();
  end
endmodule : tb
